/* File: rrs_sequencer.sv */
// Reset release sequencer: master reset timing, clock release, monitor start
`include "rrs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Any active reset source asserts master reset
// R2 - Release only after power-on and timer delays
// R3 - Delay chosen by reset type
// R4 - Power-up delay 64 ms when regulator disabled; code applies it on power-on and brown-out, ignoring regulator_disable_pin
// R5 - Eleven-bit counter waits 1024 oscillator periods
// R6 - Clock delays run alongside reset delay
// R7 - Clock delay follows selected source
// R8 - No execution until valid clock released
// R9 - Two-speed start uses fast RC timing
// R10 - Clock monitor starts at reset release
// R11 - No clock at release switches to RC, traps
// R12 - Most registers reset alike for all types
// R13 - Cause and oscillator values depend on type
// R14 - Calibration and memory control reset only on power-on
// R15 - Deep-sleep brown-out active only when enabled
// R16 - Deep-sleep brown-out re-arms power-on reset
// R17 - All delays are parameterised cycle counts
module rrs_sequencer
  import rrs_pkg::*;
#(
  parameter int unsigned PUD_CYC    = `RRS_PUD_CYC,     // R17
  parameter int unsigned POR_CYC    = `RRS_POR_CYC,
  parameter int unsigned RST_CYC    = `RRS_RST_CYC,
  parameter int unsigned FASTRC_CYC = `RRS_FASTRC_CYC,
  parameter int unsigned LPRC_CYC   = `RRS_LPRC_CYC,
  parameter int unsigned LOCK_CYC   = `RRS_LOCK_CYC,
  parameter int unsigned OSU_N      = `RRS_OSU_PERIODS
)
(
  // Clock and block reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Reset sources, levels
  input  wire logic        src_por,
  input  wire logic        src_bor,
  input  wire logic        src_pin,
  input  wire logic        src_swr,
  input  wire logic        src_wdt,
  input  wire logic        src_cm,
  input  wire logic        src_trap,
  input  wire logic        src_iop,
  // Configuration
  input  wire logic        regulator_disable_pin,
  input  wire logic [2:0]  initial_osc_select_bits,
  input  wire logic [2:0]  current_osc_bits,
  input  wire logic        clock_switch_en,
  input  wire logic        two_speed_en,
  input  wire logic        monitor_en,
  input  wire logic        deep_sleep_brownout_enable,
  input  wire logic        deep_sleep_mode,
  input  wire logic        vdd_below_por,
  // Oscillator side
  input  wire logic        osc_tick,
  input  wire logic        osc_running,
  input  wire logic        pll_locked,
  // Outputs
  output logic             master_reset_out,
  output logic             clock_released,
  output logic             cpu_run,
  output logic             clock_fail_monitor,
  output logic             fast_internal_rc_osc,
  output logic             trap_service_routine,
  output logic             deep_sleep_brownout,
  output logic [15:0]      reset_cause_register,
  output logic [15:0]      oscillator_control_register,
  output logic [15:0]      clock_calibration_register,
  output logic [15:0]      nvm_control_register,
  output logic [15:0]      sfr_reset_value
);

  // Wide enough for the longest sum of delays
  localparam int CW = 32;

  // Cycle count of the clock delay for a source
  function automatic logic [CW-1:0] clk_delay(input logic [2:0] sel, input logic two);
    logic [CW-1:0] d;
    d = '0;
    if (two)
      d = FASTRC_CYC; // R9
    else if (sel == RRS_SRC_FASTRC)
      d = FASTRC_CYC; // R7
    else if (sel == RRS_SRC_LPRC)
      d = LPRC_CYC;
    else if (sel == RRS_SRC_ECPLL)
      d = LOCK_CYC;
    else if (sel == RRS_SRC_FRCPLL)
      d = FASTRC_CYC + LOCK_CYC;
    else if (sel == RRS_SRC_XTPLL)
      d = LOCK_CYC;
    return d;
  endfunction

  // Deep-sleep re-arm turns a supply drop into a power-on event
  logic dsb_active;
  logic por_any;
  logic any_src;
  assign dsb_active = deep_sleep_brownout_enable & deep_sleep_mode;  // R15
  assign por_any    = src_por | (dsb_active & vdd_below_por);          // R16
  assign any_src    = por_any | src_bor | src_pin | src_swr | src_wdt
                    | src_cm | src_trap | src_iop;

  // Sequencer state
  rrs_state_t    st_r, st_nxt;
  logic [CW-1:0] rcnt_r, rcnt_nxt;          // Master reset delay counter
  logic [CW-1:0] ccnt_r, ccnt_nxt;          // Clock delay counter
  logic [`RRS_OSU_BITS:0] osu_r, osu_nxt;   // Oscillator period counter
  logic          xtal_r, xtal_nxt;          // Crystal wait active
  logic          pll_r, pll_nxt;            // PLL lock wait active
  logic          mrst_r, mrst_nxt;
  logic          crel_r, crel_nxt;
  logic          mon_r, mon_nxt;
  logic          rco_r, rco_nxt;            // Running from fast RC
  logic          trap_r, trap_nxt;
  logic [15:0]   cause_r, cause_nxt;
  logic [15:0]   osc_r, osc_nxt;
  logic [15:0]   cal_r, cal_nxt;
  logic [15:0]   nvm_r, nvm_nxt;
  logic [2:0]    sel;

  // Next state: reset counts and clock counts in parallel
  always_comb
  begin
    st_nxt    = st_r;
    rcnt_nxt  = rcnt_r;
    ccnt_nxt  = ccnt_r;
    osu_nxt   = osu_r;
    xtal_nxt  = xtal_r;
    pll_nxt   = pll_r;
    mrst_nxt  = mrst_r;
    crel_nxt  = crel_r;
    mon_nxt   = mon_r;
    rco_nxt   = rco_r;
    trap_nxt  = trap_r;
    cause_nxt = cause_r;
    osc_nxt   = osc_r;
    cal_nxt   = cal_r;
    nvm_nxt   = nvm_r;
    // Source choice: config bits after power-on/brown-out or with switching off, else current
    sel = (por_any | src_bor | ~clock_switch_en) ? initial_osc_select_bits
                                                 : current_osc_bits;
    if (any_src)
    begin
      // Sources held: reload delays, type decides the length
      st_nxt   = RRS_ST_HOLD;
      mrst_nxt = 1'b1;                                        // R1
      crel_nxt = 1'b0;                                        // R8
      mon_nxt  = 1'b0;
      trap_nxt = 1'b0;
      if (por_any)
        rcnt_nxt = CW'(POR_CYC) + CW'(RST_CYC) + CW'(PUD_CYC); // R3 R4
      else if (src_bor)
        rcnt_nxt = CW'(RST_CYC) + CW'(PUD_CYC);               // R3
      else
        rcnt_nxt = CW'(RST_CYC);                              // R3
      ccnt_nxt = clk_delay(sel, two_speed_en);                // R7
      xtal_nxt = ~two_speed_en & ((sel == RRS_SRC_XTAL) | (sel == RRS_SRC_XTPLL));
      pll_nxt  = ~two_speed_en & ((sel == RRS_SRC_ECPLL) | (sel == RRS_SRC_FRCPLL)
                                | (sel == RRS_SRC_XTPLL));
      osu_nxt  = '0;
      rco_nxt  = two_speed_en | (sel == RRS_SRC_FASTRC) | (sel == RRS_SRC_FRCPLL); // R9
      // Sticky cause bits set by type; power-on clears the rest
      if (por_any)
        cause_nxt = `RRS_CAUSE_POR;                           // R13
      else
      begin
        if (src_bor)  cause_nxt = cause_nxt | `RRS_CAUSE_BOR;
        if (src_pin)  cause_nxt = cause_nxt | `RRS_CAUSE_EXT;
        if (src_swr)  cause_nxt = cause_nxt | `RRS_CAUSE_SWR;
        if (src_wdt)  cause_nxt = cause_nxt | `RRS_CAUSE_WDT;
        if (src_cm)   cause_nxt = cause_nxt | `RRS_CAUSE_CM;
        if (src_trap) cause_nxt = cause_nxt | `RRS_CAUSE_TRAP;
        if (src_iop)  cause_nxt = cause_nxt | `RRS_CAUSE_IOP;
      end
      osc_nxt = {1'b0, (two_speed_en ? `RRS_SRC_FASTRC : sel), 12'h000};  // R13
      if (por_any)
      begin
        cal_nxt = `RRS_CALIB_RST;                             // R14
        nvm_nxt = `RRS_NVM_RST;                               // R14
      end
    end
    else
    begin
      // Clock timers run whether or not master reset is still held
      if (ccnt_r != '0)
        ccnt_nxt = ccnt_r - CW'(1);                           // R6
      if (xtal_r && osc_running && osc_tick && osu_r != (`RRS_OSU_BITS+1)'(OSU_N))
        osu_nxt = osu_r + 1'b1;                               // R5
      case (st_r)
        RRS_ST_HOLD:
        begin
          st_nxt = RRS_ST_COUNT;
        end
        RRS_ST_COUNT:
        begin
          // Release once every master reset delay has run out
          if (rcnt_r <= CW'(1))
          begin
            rcnt_nxt = '0;
            mrst_nxt = 1'b0;                                  // R2
            st_nxt   = RRS_ST_RUN;
            mon_nxt  = monitor_en;                            // R10
            // Monitor finds no valid clock: fall back to RC and trap
            if (monitor_en && (xtal_r ? ~osc_running : 1'b0))
            begin
              rco_nxt  = 1'b1;                                // R11
              trap_nxt = 1'b1;                                // R11
              xtal_nxt = 1'b0;
              pll_nxt  = 1'b0;
              osc_nxt  = {1'b0, `RRS_SRC_FASTRC, 12'h000};
            end
          end
          else
            rcnt_nxt = rcnt_r - CW'(1);
        end
        default:
        begin
          st_nxt = RRS_ST_RUN;
        end
      endcase
      // Clock goes to the system only when all start-up waits are over
      if (!mrst_r && ccnt_r == '0 && (!xtal_r || osu_r == (`RRS_OSU_BITS+1)'(OSU_N))
          && (!pll_r || pll_locked))
        crel_nxt = 1'b1;                                      // R8
    end
  end

  // Register all sequencer state; the deep-sleep and run flops follow below
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_r    <= RRS_ST_HOLD;
      rcnt_r  <= CW'(POR_CYC) + CW'(RST_CYC) + CW'(PUD_CYC);
      ccnt_r  <= '0;
      osu_r   <= '0;
      xtal_r  <= 1'b0;
      pll_r   <= 1'b0;
      mrst_r  <= 1'b1;
      crel_r  <= 1'b0;
      mon_r   <= 1'b0;
      rco_r   <= 1'b1;
      trap_r  <= 1'b0;
      cause_r <= `RRS_CAUSE_POR;
      osc_r   <= 16'h0000;
      cal_r   <= `RRS_CALIB_RST;
      nvm_r   <= `RRS_NVM_RST;
    end
    else
    begin
      st_r    <= st_nxt;
      rcnt_r  <= rcnt_nxt;
      ccnt_r  <= ccnt_nxt;
      osu_r   <= osu_nxt;
      xtal_r  <= xtal_nxt;
      pll_r   <= pll_nxt;
      mrst_r  <= mrst_nxt;
      crel_r  <= crel_nxt;
      mon_r   <= mon_nxt;
      rco_r   <= rco_nxt;
      trap_r  <= trap_nxt;
      cause_r <= cause_nxt;
      osc_r   <= osc_nxt;
      cal_r   <= cal_nxt;
      nvm_r   <= nvm_nxt;
    end
  end

  // Status flop for the deep-sleep detector
  logic dsb_r;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dsb_r <= 1'b0;
    else
      dsb_r <= dsb_active;                                    // R15
  end

  // Run flop: CPU starts one cycle after the clock is released,
  // so code never sees the edge on which the clock first arrives
  logic run_r;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      run_r <= 1'b0;
    else
      run_r <= crel_r & ~mrst_nxt;                            // R8
  end

  // Outputs straight from flops or a constant
  assign master_reset_out            = mrst_r;
  assign clock_released              = crel_r;
  assign cpu_run                     = run_r;
  assign clock_fail_monitor          = mon_r;
  assign fast_internal_rc_osc        = rco_r;
  assign trap_service_routine        = trap_r;
  assign deep_sleep_brownout         = dsb_r;
  assign reset_cause_register        = cause_r;
  assign oscillator_control_register = osc_r;
  assign clock_calibration_register  = cal_r;
  assign nvm_control_register        = nvm_r;
  assign sfr_reset_value             = `RRS_SFR_RST;          // R12

endmodule
`default_nettype wire

/* File: rrs_defines.svh */
// Constants for the reset release sequencer
`ifndef RRS_DEFINES_SVH
`define RRS_DEFINES_SVH
`define RRS_CLK_HZ        40000000
`define RRS_PUD_MS        64
`define RRS_PUD_CYC       ((`RRS_CLK_HZ / 1000) * `RRS_PUD_MS)
`define RRS_POR_US        10
`define RRS_POR_CYC       ((`RRS_CLK_HZ / 1000000) * `RRS_POR_US)
`define RRS_RST_US        10
`define RRS_RST_CYC       ((`RRS_CLK_HZ / 1000000) * `RRS_RST_US)
`define RRS_FASTRC_US     15
`define RRS_FASTRC_CYC    ((`RRS_CLK_HZ / 1000000) * `RRS_FASTRC_US)
`define RRS_LPRC_US       100
`define RRS_LPRC_CYC      ((`RRS_CLK_HZ / 1000000) * `RRS_LPRC_US)
`define RRS_LOCK_US       2000
`define RRS_LOCK_CYC      ((`RRS_CLK_HZ / 1000000) * `RRS_LOCK_US)
`define RRS_OSU_PERIODS   1024
`define RRS_OSU_BITS      10
`define RRS_CAUSE_POR     16'h0003
`define RRS_CAUSE_BOR     16'h0002
`define RRS_CAUSE_EXT     16'h0080
`define RRS_CAUSE_SWR     16'h0040
`define RRS_CAUSE_WDT     16'h0010
`define RRS_CAUSE_CM      16'h0200
`define RRS_CAUSE_TRAP    16'h8000
`define RRS_CAUSE_IOP     16'h4000
`define RRS_SRC_FASTRC    3'h1
`define RRS_CALIB_RST     16'h0000
`define RRS_SFR_RST       16'h0000
`define RRS_NVM_RST       16'h0000
`define RRS_OSC_SEL_POS   12
`endif

/* File: rrs_pkg.sv */
// Types for the reset release sequencer
`default_nettype none
package rrs_pkg;
  typedef enum logic [2:0] {
    RRS_SRC_EC, RRS_SRC_FASTRC, RRS_SRC_LPRC, RRS_SRC_ECPLL,
    RRS_SRC_FRCPLL, RRS_SRC_XTAL, RRS_SRC_XTPLL
  } rrs_src_t;
  typedef enum logic [1:0] { RRS_ST_RUN, RRS_ST_HOLD, RRS_ST_COUNT } rrs_state_t;
endpackage
`default_nettype wire

/* File: rrs_osc_model.sv */
// Oscillator and PLL model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module rrs_osc_model
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Crystal powered and swinging
  input  wire logic osc_en,
  // Towards the sequencer
  output logic      osc_tick,
  output logic      osc_running,
  output logic      pll_locked
);
  logic [3:0] age_r; // Cycles since start, saturates
  logic       ph_r;  // Half of the crystal period
  // Slow crystal: one tick every other cycle
  always_ff @(posedge clk_sys)
  begin
    ph_r  <= (rst || !osc_en) ? 1'b0 : !ph_r;
    age_r <= (rst || !osc_en) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
  end
  assign osc_running = osc_en;
  assign osc_tick    = osc_en && ph_r;
  assign pll_locked  = age_r >= 4'hC; // Lock lags the crystal start
endmodule
`default_nettype wire

/* File: rrs_sequencer_assertions.sv */
// Checker for the reset release sequencer
`timescale 1ns/1ps
`default_nettype none
module rrs_sequencer_checker
#(
  parameter int unsigned RST_CYC = 10
)
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Reset sources
  input wire logic        src_por,
  input wire logic        src_bor,
  input wire logic        src_pin,
  input wire logic        src_swr,
  input wire logic        src_wdt,
  input wire logic        src_cm,
  input wire logic        src_trap,
  input wire logic        src_iop,
  // Configuration
  input wire logic        monitor_en,
  input wire logic        deep_sleep_brownout_enable,
  input wire logic        deep_sleep_mode,
  input wire logic        vdd_below_por,
  // Watched outputs
  input wire logic        master_reset_out,
  input wire logic        clock_released,
  input wire logic        cpu_run,
  input wire logic        clock_fail_monitor,
  input wire logic        fast_internal_rc_osc,
  input wire logic        trap_service_routine,
  input wire logic        deep_sleep_brownout,
  input wire logic [15:0] reset_cause_register,
  input wire logic [15:0] clock_calibration_register,
  input wire logic [15:0] nvm_control_register
);
  logic        any_src;  // Some source active
  logic        rearm;    // Supply drop in deep sleep
  logic [31:0] hold_r;   // Quiet cycles with reset held
  logic [31:0] hold_nxt;
  assign any_src = |{src_por, src_bor, src_pin, src_swr, src_wdt, src_cm, src_trap, src_iop};
  assign rearm   = deep_sleep_brownout_enable && deep_sleep_mode && vdd_below_por;
  // Count held cycles once sources are quiet
  always_comb
  begin
    hold_nxt = (master_reset_out && !any_src) ? hold_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys)
  begin
    hold_r <= rst ? 32'h0 : hold_nxt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_src_holds_reset: assert property (any_src |=> master_reset_out)
    else $error("source did not hold master reset");
  a_release_delay: assert property ($fell(master_reset_out) |-> hold_r >= RST_CYC)
    else $error("master reset released early");
  a_run_needs_clock: assert property (cpu_run |-> clock_released && !master_reset_out)
    else $error("cpu runs without clock");
  a_run_after_clock: assert property ($rose(cpu_run) |-> $past(clock_released))
    else $error("cpu started before clock release");
  a_monitor_starts: assert property (monitor_en && $fell(master_reset_out) |->
    ##[0:2] (clock_fail_monitor || trap_service_routine))
    else $error("monitor did not start at release");
  a_monitor_not_early: assert property (clock_fail_monitor |-> !master_reset_out)
    else $error("monitor active in reset");
  a_fail_uses_rc: assert property (trap_service_routine |-> fast_internal_rc_osc)
    else $error("trap without rc switch");
  a_dsb_needs_en: assert property (deep_sleep_brownout |-> $past(deep_sleep_brownout_enable))
    else $error("deep sleep detector active while off");
  a_rearm_full_por: assert property (rearm |->
    ##[1:3] (master_reset_out && reset_cause_register == 16'h0003))
    else $error("deep sleep drop gave no full reset");
  a_por_cause: assert property (src_por |-> ##[1:3] reset_cause_register == 16'h0003)
    else $error("power-on cause value wrong");
  a_calib_por_only: assert property (!src_por && !rearm |=>
    $stable(clock_calibration_register) && $stable(nvm_control_register))
    else $error("calibration or memory control changed");
  c_release: cover property ($fell(master_reset_out));
  c_run: cover property ($rose(cpu_run));
  c_trap: cover property ($rose(trap_service_routine));
endmodule
bind rrs_sequencer rrs_sequencer_checker #(.RST_CYC(RST_CYC)) u_chk (.*);
`default_nettype wire

/* File: reset_release_sequencer_tb.sv */
// Self-checking bench for the reset release sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_release_sequencer_tb;
  import rrs_pkg::*;
  // Shortened counts keep the run brief
  localparam int unsigned PUD  = 20;
  localparam int unsigned PORC = 5;
  localparam int unsigned RSTC = 6;
  logic        clk_sys = 1'b0; // 40 MHz
  logic        rst     = 1'b1; // Bench reset
  logic [7:0]  src     = 8'h00; // por bor pin swr wdt cm trap iop
  logic [2:0]  osc     = 3'h0; // Oscillator selection
  logic [3:0]  cfg     = 4'h0; // switch, two-speed, monitor, deep-sleep
  logic        dsleep  = 1'b0; // Deep sleep mode
  logic        vdd_low = 1'b0; // Supply below power-on level
  logic        osc_en  = 1'b1; // Crystal swinging
  logic        osc_tick, osc_running, pll_locked, master_reset_out, clock_released, cpu_run;
  logic        trap_service_routine, fast_internal_rc_osc, deep_sleep_brownout;
  logic [15:0] cause;
  logic [15:0] oscr;
  logic        cfm;  // Clock monitor active
  logic [15:0] sfr;  // Common register reset value
  int          seed, i, n, cycles, compares, miscompares;
  rrs_osc_model osc_i (.clk_sys, .rst, .osc_en, .osc_tick, .osc_running, .pll_locked);
  rrs_sequencer #(.PUD_CYC(PUD), .POR_CYC(PORC), .RST_CYC(RSTC), .FASTRC_CYC(7),
    .LPRC_CYC(8), .LOCK_CYC(9), .OSU_N(4)) uut (.clk_sys, .rst,
    .src_por(src[0]), .src_bor(src[1]), .src_pin(src[2]), .src_swr(src[3]),
    .src_wdt(src[4]), .src_cm(src[5]), .src_trap(src[6]), .src_iop(src[7]),
    .regulator_disable_pin(1'b1), .initial_osc_select_bits(osc),
    .current_osc_bits(3'h6 - osc),
    .clock_switch_en(cfg[0]), .two_speed_en(cfg[1]), .monitor_en(cfg[2]),
    .deep_sleep_brownout_enable(cfg[3]), .deep_sleep_mode(dsleep), .vdd_below_por(vdd_low),
    .osc_tick, .osc_running, .pll_locked, .master_reset_out, .clock_released, .cpu_run,
    .clock_fail_monitor(cfm), .fast_internal_rc_osc, .trap_service_routine,
    .deep_sleep_brownout, .reset_cause_register(cause), .oscillator_control_register(oscr),
    .clock_calibration_register(), .nvm_control_register(), .sfr_reset_value(sfr));
  // Cause bits each source should leave behind
  function automatic logic [31:0] cause_of(input int k);
    logic [15:0] t [8];
    t = '{16'h0003, 16'h0002, 16'h0080, 16'h0040, 16'h0010, 16'h0200, 16'h8000, 16'h4000};
    return {16'h0, t[k]};
  endfunction
  // Release delay by reset type
  function automatic int delay_of(input int k);
    return (k == 0) ? PORC + RSTC + PUD : ((k == 1) ? RSTC + PUD : RSTC);
  endfunction
  // Single compare used for every result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait on master reset (0) or cpu run (1)
  task automatic wait_lvl(input int which, input logic val, output int cnt);
    cnt = 0;
    while (((which == 1) ? cpu_run : master_reset_out) !== val && cnt < 400)
    begin
      @(posedge clk_sys);
      #2;
      cnt++;
    end
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the expected run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    seed = 32'h16d7;
    repeat (6) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    wait_lvl(0, 1'b0, n);
    chk(n >= delay_of(0) && n <= delay_of(0) + 4, 1);
    // Every source in turn, then random ones
    for (int k = 0; k < 24; k++)
    begin
      i = (k < 8) ? k : $unsigned($random(seed)) % 8;
      osc = 3'($unsigned($random(seed)) % 7);
      cfg = 4'($unsigned($random(seed)) % 8);
      src[i] = 1'b1;
      repeat (1 + $unsigned($random(seed)) % 4) @(posedge clk_sys);
      #2;
      chk(master_reset_out, 1);
      src = 8'h00;
      wait_lvl(0, 1'b0, n);
      chk(n >= delay_of(i) && n <= delay_of(i) + 4, 1);
      chk((i == 0) ? {16'h0, cause} : {16'h0, cause} & cause_of(i), cause_of(i));
      chk(oscr[14:12], cfg[1] ? 3'h1 : ((i < 2 || !cfg[0]) ? osc : 3'h6 - osc));
      chk(sfr, 16'h0000);
      wait_lvl(1, 1'b1, n);
      chk(cpu_run, 1);
      chk(cfm, cfg[2]);
      if (i == 0)
        chk(n <= 4, 1);
    end
    // Dead crystal at release: fall back to RC and trap
    osc_en = 1'b0;
    osc = 3'h5;
    cfg = 4'h4;
    src[0] = 1'b1;
    @(posedge clk_sys);
    #2;
    src = 8'h00;
    wait_lvl(0, 1'b0, n);
    repeat (3) @(posedge clk_sys);
    #2;
    chk({trap_service_routine, fast_internal_rc_osc, cfm, oscr[14:12]}, {3'b111, 3'h1});
    osc_en = 1'b1;
    // Deep-sleep supply drop, detector on then off
    cfg = 4'h8;
    dsleep = 1'b1;
    vdd_low = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2;
    chk({master_reset_out, deep_sleep_brownout, cause}, {2'b11, 16'h0003});
    vdd_low = 1'b0;
    wait_lvl(0, 1'b0, n);
    cfg = 4'h0;
    vdd_low = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2;
    chk({master_reset_out, deep_sleep_brownout}, 2'b00);
    report_and_stop();
  end
endmodule
`default_nettype wire
